// *** logic/pbwc_defs.svh ***
/*
 * Command codes, reset values, battery threshold constants and timing counts.
 * Assumes a 20 MHz clock and 16-bit words sent MSB first.
 */
// What this block does
// R1 - Upper byte CAh loads button configuration; reset CA00h.
// R2 - Dual-key enable makes keys one and two together act as key four.
// R3 - Debounce select: 00=160 ms, 01=40 ms, 10=10 ms, 11=none.
// R4 - Bits four to one make that key's routine repeat while held.
// R5 - Pull-up disable bit turns off key pull-ups; clear after reset.
// R6 - Sleep command kills amp and synth now, oscillator after count cycles.
// R7 - Wake interval is multiplier times two to the exponent.
// R8 - Wake period command is code 111 in bits fifteen to thirteen.
// R9 - Host clears then sets wake timer enable each wake cycle.
// R10 - Host writes zeros to unused threshold bits seven to five.
// R11 - Low battery flag sets when supply is 50 mV under threshold.
// R12 - Battery monitor runs only while its enable bit is set.
// R13 - Auto chain select chooses manual, amp-after-lock, osc-synth, or both.
// R14 - Auto oscillator mode starts osc on transmit, synth once stable.
// R15 - Power bits five, four, three enable oscillator, synth, amplifier.
// R16 - Each synthesizer enable starts a fresh VCO calibration.
// R17 - Host programs frequency and band before enabling the synthesizer.
// R18 - Wake timer counts only while its enable bit is set.
// R19 - Clock out disable stops clock output; active after reset.
// R20 - Power word C001h disables all and stops clock output.
// R21 - With clock output left enabled, oscillator keeps running.
// R22 - Threshold steps 0.1 V per code from 2.2 V.
// R23 - Words shift in MSB first; applied only after a full frame.
// R24 - Wake interval counts a fixed internal timebase tick.
`ifndef PBWC_DEFS_SVH
`define PBWC_DEFS_SVH

`define PBWC_CODE_BUTTON    8'hca
`define PBWC_CODE_SLEEP     8'hc4
`define PBWC_CODE_BATT      8'hc2
`define PBWC_CODE_POWER     8'hc0
`define PBWC_CODE_WAKE      3'h7
`define PBWC_CODE_XMIT      8'hc6

`define PBWC_RST_BUTTON     16'hca00
`define PBWC_RST_SLEEP      16'hc400
`define PBWC_RST_WAKE       16'he000
`define PBWC_RST_BATT       16'hc200
`define PBWC_RST_POWER      16'hc000

`define PBWC_CLK_HZ         20000000
`define PBWC_DB160_MS       160
`define PBWC_DB40_MS        40
`define PBWC_DB10_MS        10
`define PBWC_MS_CYC(ms)     ((ms) * (`PBWC_CLK_HZ / 1000))
`define PBWC_TICK_US        1000
`define PBWC_TICK_CYC       ((`PBWC_TICK_US) * (`PBWC_CLK_HZ / 1000000))
`define PBWC_BATT_MIN_MV    2200
`define PBWC_BATT_STEP_MV   100
`define PBWC_BATT_HYST_MV   50
`define PBWC_SETTLE_CYC     16'h0100
`define PBWC_CAL_CYC        16'h0040

`endif

// *** logic/pbwc_pkg.sv ***
/*
 * Register layouts and state types.
 * Assumes nothing of its surroundings.
 */
package pbwc_pkg;

    // ****
    // Register layouts
    // ****
    typedef struct packed {
        logic [7:0] code;
        logic       dual_key_enable;
        logic [1:0] debounce_select;
        logic [3:0] repeat_enable;
        logic       pullup_disable;
    } pbwc_button_s;

    typedef struct packed {
        logic [7:0] code;
        logic [1:0] auto_chain_select;
        logic       xtal_enable;
        logic       pll_enable;
        logic       amp_enable;
        logic       battery_monitor_enable;
        logic       wake_timer_enable;
        logic       clock_out_disable;
    } pbwc_power_s;

    typedef struct packed {
        logic [2:0] code;
        logic [4:0] wake_exponent;
        logic [7:0] wake_multiplier;
    } pbwc_wake_s;

    typedef struct packed {
        logic xtal_on;
        logic pll_on;
        logic amp_on;
        logic vco_cal;
        logic clock_out_on;
    } pbwc_rf_s;

    typedef enum logic [2:0] {
        PBWC_RUN,
        PBWC_OSC_WAIT,
        PBWC_SYN_WAIT,
        PBWC_SLEEP_WAIT,
        PBWC_ASLEEP
    } pbwc_pwr_e;

endpackage : pbwc_pkg

// *** logic/pbwc_shift_rx.sv ***
/*
 * Serial receiver: 16-bit words MSB first on rising link clock.
 * Assumes all three link pins are asynchronous.
 */
module pbwc_shift_rx (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        sck,
    input  wire logic        sdi,
    input  wire logic        sel_n,
    output logic [15:0]      word,
    output logic             word_valid
);
    logic [2:0]  sck_sync_reg;
    logic [1:0]  sdi_sync_reg;
    logic [1:0]  sel_sync_reg;
    logic [15:0] shift_reg;
    logic [4:0]  count_reg;

    wire rise   = sck_sync_reg[1] & ~sck_sync_reg[2];
    wire active = ~sel_sync_reg[1];
    wire last   = rise & active & (count_reg == 5'h0f);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sck_sync_reg <= 3'h0;
            sdi_sync_reg <= 2'h0;
            sel_sync_reg <= 2'h3;
        end else begin
            sck_sync_reg <= {sck_sync_reg[1:0], sck};
            sdi_sync_reg <= {sdi_sync_reg[0], sdi};
            sel_sync_reg <= {sel_sync_reg[0], sel_n};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shift_reg  <= 16'h0000;
            count_reg  <= 5'h00;
            word       <= 16'h0000;
            word_valid <= 1'b0;
        end else begin
            word_valid <= last; // R23
            if (!active) begin
                count_reg <= 5'h00;
            end else if (rise) begin
                shift_reg <= {shift_reg[14:0], sdi_sync_reg[1]}; // R23
                count_reg <= last ? 5'h00 : count_reg + 5'h01;
            end
            if (last) begin
                word <= {shift_reg[14:0], sdi_sync_reg[1]};
            end
        end
    end

endmodule : pbwc_shift_rx

// *** logic/pbwc_key_filter.sv ***
/*
 * Key debounce: level passes once stable for the given count.
 * Assumes the pin is low when pressed; zero count means none.
 */
module pbwc_key_filter (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        key_n,
    input  wire logic [21:0] limit,
    output logic             pressed
);
    logic [1:0]  sync_reg;
    logic [21:0] cnt_reg;

    wire raw  = ~sync_reg[1];
    wire diff = raw != pressed;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_reg <= 2'h3;
            cnt_reg  <= 22'h0;
            pressed  <= 1'b0;
        end else begin
            sync_reg <= {sync_reg[0], key_n};
            if (!diff) begin
                cnt_reg <= 22'h0;
            end else if (cnt_reg >= limit) begin
                pressed <= raw;
                cnt_reg <= 22'h0;
            end else begin
                cnt_reg <= cnt_reg + 22'h1;
            end
        end
    end

endmodule : pbwc_key_filter

// *** logic/pbwc_top.sv ***
/*
 * Power, button and wake control: command decode and power sequencing.
 * Assumes async pins; analog side reports lock, stability and supply in mV.
 */
`include "pbwc_defs.svh"

module pbwc_top #(
    parameter int DB160_CYC = `PBWC_MS_CYC(`PBWC_DB160_MS),
    parameter int DB40_CYC  = `PBWC_MS_CYC(`PBWC_DB40_MS),
    parameter int DB10_CYC  = `PBWC_MS_CYC(`PBWC_DB10_MS),
    parameter int TICK_CYC  = `PBWC_TICK_CYC
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              sck,
    input  wire logic              sdi,
    input  wire logic              sel_n,
    input  wire logic [3:0]        key_n,
    input  wire logic              osc_stable,
    input  wire logic              pll_locked,
    input  wire logic [12:0]       supply_mv,
    output logic [3:0]             key_pullup_on,
    output logic [3:0]             key_run,
    output logic                   combo_run,
    output pbwc_pkg::pbwc_rf_s     rf,
    output logic                   battery_low_flag,
    output logic                   wake_event,
    output logic                   asleep
);
    import pbwc_pkg::*;

    initial begin
        if (DB160_CYC >= (1 << 22) || DB10_CYC < 1 || TICK_CYC < 1) begin
            $error("count parameter out of range");
        end
    end

    // ****
    // Command intake and decode
    // ****
    logic [15:0] word;
    logic        word_valid;

    pbwc_shift_rx u_rx (
        .clk        (clk),
        .rst        (rst),
        .sck        (sck),
        .sdi        (sdi),
        .sel_n      (sel_n),
        .word       (word),
        .word_valid (word_valid)
    );

    wire hit_button = word_valid && word[15:8] == `PBWC_CODE_BUTTON; // R1
    wire hit_sleep  = word_valid && word[15:8] == `PBWC_CODE_SLEEP;
    wire hit_batt   = word_valid && word[15:8] == `PBWC_CODE_BATT;
    wire hit_power  = word_valid && word[15:8] == `PBWC_CODE_POWER;
    wire hit_xmit   = word_valid && word[15:8] == `PBWC_CODE_XMIT;
    wire hit_wake   = word_valid && word[15:13] == `PBWC_CODE_WAKE; // R8

    // ****
    // Settings registers
    // ****
    pbwc_button_s button_reg;
    logic [15:0]  sleep_reg;
    pbwc_wake_s   wake_reg;
    logic [15:0]  batt_reg;
    pbwc_power_s  power_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            button_reg <= `PBWC_RST_BUTTON; // R1
            sleep_reg  <= `PBWC_RST_SLEEP;
            wake_reg   <= `PBWC_RST_WAKE;
            batt_reg   <= `PBWC_RST_BATT;
            power_reg  <= `PBWC_RST_POWER; // R19
        end else begin
            if (hit_button) button_reg <= word; // R1
            if (hit_sleep)  sleep_reg  <= word;
            if (hit_wake)   wake_reg   <= word; // R8
            if (hit_batt)   batt_reg   <= word;
            if (hit_power)  power_reg  <= word; // R20
        end
    end

    // ****
    // Keys
    // ****
    wire [21:0] db_limit =
        button_reg.debounce_select == 2'h0 ? 22'(DB160_CYC) :
        button_reg.debounce_select == 2'h1 ? 22'(DB40_CYC)  :
        button_reg.debounce_select == 2'h2 ? 22'(DB10_CYC)  : 22'h0; // R3

    logic [3:0] pressed;
    logic [3:0] pressed_d_reg;

    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_key
            pbwc_key_filter u_key (
                .clk     (clk),
                .rst     (rst),
                .key_n   (key_n[k]),
                .limit   (db_limit),
                .pressed (pressed[k])
            );
        end
    endgenerate

    wire       combo    = button_reg.dual_key_enable & pressed[0] & pressed[1]; // R2
    logic      combo_d_reg;
    wire [3:0] new_press = pressed & ~pressed_d_reg;
    wire [3:0] key_fire  = new_press | (pressed & button_reg.repeat_enable); // R4
    wire       combo_new = combo & ~combo_d_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pressed_d_reg <= 4'h0;
            combo_d_reg   <= 1'b0;
            key_run       <= 4'h0;
            combo_run     <= 1'b0;
            key_pullup_on <= 4'hf;
        end else begin
            pressed_d_reg <= pressed;
            combo_d_reg   <= combo;
            key_run       <= key_fire;
            combo_run     <= combo_new | (combo & button_reg.repeat_enable[3]); // R2
            key_pullup_on <= {4{~button_reg.pullup_disable}}; // R5
        end
    end

    // ****
    // Wake timer
    // ****
    logic [31:0] tick_cnt_reg;
    logic [39:0] wake_cnt_reg;
    wire  [39:0] wake_span = 40'(wake_reg.wake_multiplier) << wake_reg.wake_exponent; // R7
    wire         tick      = tick_cnt_reg == 32'(TICK_CYC - 1); // R24

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_cnt_reg <= 32'h0;
            wake_cnt_reg <= 40'h0;
            wake_event   <= 1'b0;
        end else begin
            wake_event <= 1'b0;
            if (!power_reg.wake_timer_enable) begin
                tick_cnt_reg <= 32'h0; // R18
                wake_cnt_reg <= 40'h0;
            end else if (tick) begin
                tick_cnt_reg <= 32'h0;
                if (wake_cnt_reg + 40'h1 >= wake_span) begin
                    wake_event   <= 1'b1; // R18
                    wake_cnt_reg <= 40'h0;
                end else begin
                    wake_cnt_reg <= wake_cnt_reg + 40'h1;
                end
            end else begin
                tick_cnt_reg <= tick_cnt_reg + 32'h1;
            end
        end
    end

    // ****
    // Battery monitor
    // ****
    wire [12:0] thresh_mv = 13'(`PBWC_BATT_MIN_MV)
                          + 13'(batt_reg[4:0]) * 13'(`PBWC_BATT_STEP_MV); // R22
    wire        below     = supply_mv + 13'(`PBWC_BATT_HYST_MV) <= thresh_mv; // R11

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            battery_low_flag <= 1'b0;
        end else if (!power_reg.battery_monitor_enable) begin
            battery_low_flag <= 1'b0; // R12
        end else begin
            battery_low_flag <= below; // R11
        end
    end

    // ****
    // Power sequencing
    // ****
    pbwc_pwr_e   state_reg;
    logic [7:0]  sleep_cnt_reg;
    logic        auto_xtal_reg;
    logic        auto_pll_reg;
    logic        pll_d_reg;
    logic [15:0] cal_cnt_reg;

    wire auto_osc = power_reg.auto_chain_select[1]; // R13
    wire auto_amp = power_reg.auto_chain_select[0]; // R13

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg     <= PBWC_RUN;
            sleep_cnt_reg <= 8'h00;
            auto_xtal_reg <= 1'b0;
            auto_pll_reg  <= 1'b0;
        end else begin
            case (state_reg)
                PBWC_RUN: begin
                    if (hit_sleep) begin
                        sleep_cnt_reg <= word[7:0];
                        state_reg     <= PBWC_SLEEP_WAIT; // R6
                    end else if (hit_xmit && auto_osc) begin
                        auto_xtal_reg <= 1'b1; // R14
                        state_reg     <= PBWC_OSC_WAIT;
                    end
                end
                PBWC_OSC_WAIT: begin
                    if (hit_sleep) begin
                        auto_xtal_reg <= 1'b0;
                        sleep_cnt_reg <= word[7:0];
                        state_reg     <= PBWC_SLEEP_WAIT;
                    end else if (osc_stable) begin
                        auto_pll_reg <= 1'b1; // R14
                        state_reg    <= PBWC_RUN;
                    end
                end
                PBWC_SLEEP_WAIT: begin
                    auto_xtal_reg <= 1'b0;
                    auto_pll_reg  <= 1'b0;
                    if (sleep_cnt_reg == 8'h00) begin
                        state_reg <= PBWC_ASLEEP; // R6
                    end else begin
                        sleep_cnt_reg <= sleep_cnt_reg - 8'h01;
                    end
                end
                PBWC_ASLEEP: begin
                    if (hit_power || hit_xmit || wake_event) begin
                        state_reg <= PBWC_RUN;
                    end
                end
                default: begin
                    state_reg <= PBWC_RUN;
                end
            endcase
            // A new power word clears both automatic enables; an oscillator wait still pending later sets the synth one
            if (hit_power) {auto_xtal_reg, auto_pll_reg} <= 2'h0; // R13
        end
    end

    wire sleeping  = state_reg == PBWC_ASLEEP;
    wire quiet     = state_reg == PBWC_SLEEP_WAIT || sleeping; // R6
    wire xtal_next = !sleeping && (power_reg.xtal_enable || auto_xtal_reg
                     || !power_reg.clock_out_disable); // R15 R21
    wire pll_next  = !quiet && (power_reg.pll_enable || auto_pll_reg); // R15 R14
    wire amp_next  = !quiet && (power_reg.amp_enable
                     || (auto_amp && pll_locked && pll_next)); // R15 R13
    wire clko_next = !sleeping && !power_reg.clock_out_disable; // R19 R20

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pll_d_reg   <= 1'b0;
            cal_cnt_reg <= 16'h0;
            rf          <= '0;
            asleep      <= 1'b0;
        end else begin
            pll_d_reg <= pll_next;
            if (pll_next && !pll_d_reg) begin
                cal_cnt_reg <= `PBWC_CAL_CYC; // R16
            end else if (cal_cnt_reg != 16'h0) begin
                cal_cnt_reg <= cal_cnt_reg - 16'h1;
            end
            rf.xtal_on      <= xtal_next;
            rf.pll_on       <= pll_next;
            rf.amp_on       <= amp_next;
            rf.vco_cal      <= (pll_next && !pll_d_reg) || cal_cnt_reg > 16'h1; // R16
            rf.clock_out_on <= clko_next;
            asleep          <= sleeping;
        end
    end

endmodule : pbwc_top

// *** verification/pbwc_sva.sv ***
/* Port checker of pbwc_top.
   Assumes a bind that hands on TICK_CYC. */
module pbwc_chk #(
    parameter int TICK_CYC = 4
) (
    input wire logic               clk,
    input wire logic               rst,
    input wire logic [3:0]         key_n,
    input wire logic [3:0]         key_pullup_on,
    input wire logic [3:0]         key_run,
    input wire logic               combo_run,
    input wire pbwc_pkg::pbwc_rf_s rf,
    input wire logic               wake_event,
    input wire logic               asleep
);
    import pbwc_pkg::*;
    logic [7:0] gap_reg;
    logic [7:0] age0_reg;
    logic [7:0] age1_reg;
    logic [7:0] up_reg;
    // ****
    // Saturating age counters
    // ****
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gap_reg  <= 8'hff;
            age0_reg <= 8'hff;
            age1_reg <= 8'hff;
            up_reg   <= 8'h00;
        end else begin
            gap_reg  <= wake_event ? 8'h00 : gap_reg + 8'(gap_reg != 8'hff);
            age0_reg <= !key_n[0] ? 8'h00 : age0_reg + 8'(age0_reg != 8'hff);
            age1_reg <= !key_n[1] ? 8'h00 : age1_reg + 8'(age1_reg != 8'hff);
            up_reg   <= up_reg + 8'(up_reg != 8'hff);
        end
    end
    // ****
    // Properties
    // ****
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_down;
        !rf.pll_on && !rf.amp_on;
    endsequence
    sequence s_off;
        !rf.xtal_on && !rf.clock_out_on;
    endsequence
    property p_pullup_equal;
        key_pullup_on == 4'h0 || key_pullup_on == 4'hf;
    endproperty
    property p_clk_after_rst;
        up_reg == 8'h02 |-> rf.clock_out_on && rf.xtal_on;
    endproperty
    property p_osc_kept;
        rf.clock_out_on |-> rf.xtal_on;
    endproperty
    property p_asleep_off;
        asleep |-> s_down and s_off;
    endproperty
    property p_sleep_entry;
        $rose(asleep) |-> !$past(rf.pll_on) && !$past(rf.amp_on);
    endproperty
    property p_cal_start;
        $rose(rf.pll_on) |-> ##[0:2] rf.vco_cal;
    endproperty
    property p_cal_hold;
        $rose(rf.vco_cal) |-> rf.vco_cal [*8];
    endproperty
    property p_wake_gap;
        wake_event |-> gap_reg >= TICK_CYC - 1;
    endproperty
    property p_key_cause;
        key_run[0] |-> age0_reg <= 8'd30;
    endproperty
    property p_combo_cause;
        combo_run |-> age0_reg <= 8'd30 && age1_reg <= 8'd30;
    endproperty
    a_pullup_equal: assert property (p_pullup_equal)
        else $error("pull-up outputs differ");
    a_clk_after_rst: assert property (p_clk_after_rst)
        else $error("clock output off after reset");
    a_osc_kept: assert property (p_osc_kept)
        else $error("osc off with clock out on");
    a_asleep_off: assert property (p_asleep_off)
        else $error("function on while asleep");
    a_sleep_entry: assert property (p_sleep_entry)
        else $error("amp or synth still on at sleep entry");
    a_cal_start: assert property (p_cal_start)
        else $error("no calibration on synth enable");
    a_cal_hold: assert property (p_cal_hold)
        else $error("calibration too short");
    a_wake_gap: assert property (p_wake_gap)
        else $error("wake pulses closer than one tick");
    a_key_cause: assert property (p_key_cause)
        else $error("key run without recent press");
    a_combo_cause: assert property (p_combo_cause)
        else $error("combo run without both keys");
    c_sleep: cover property ($rose(asleep));
endmodule : pbwc_chk

// *** verification/pbwc_host.sv ***
/* Host model: sends command words on the serial link.
   Assumes the caller waits for each frame to finish. */
module pbwc_host (
    input  wire logic clk,
    output logic      sck,
    output logic      sdi,
    output logic      sel_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sck = 1'b0;
        sdi = 1'b1;
        sel_n = 1'b1;
    end
    // Clock idles low; released data flips
    task automatic send(input logic [15:0] w, input int n);
        @(negedge clk);
        sel_n = 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            sdi = w[i];
            repeat (4) @(negedge clk);
            sck = 1'b1;
            repeat (4) @(negedge clk);
            sck = 1'b0;
        end
        repeat (4) @(negedge clk);
        sel_n = 1'b1;
        sdi = ~sdi;
    endtask : send
endmodule : pbwc_host

// *** verification/tb_power_button_wake_control.sv ***
/* Self-checking bench of pbwc_top with the host model.
   Assumes short debounce counts and a four-cycle tick. */
module tb_power_button_wake_control;
    timeunit 1ns;
    timeprecision 1ns;
    import pbwc_pkg::*;
    localparam int TICK = 4;
    logic clk = 1'b0, rst = 1'b1, sck, sdi, sel_n, osc_stable, pll_locked;
    logic [3:0] key_n, key_pullup_on, key_run;
    logic [12:0] supply_mv;
    logic combo_run, battery_low_flag, wake_event, asleep;
    pbwc_rf_s rf;
    int n_fail = 0, checked = 0, cyc = 0;
    pbwc_host host_u (.clk, .sck, .sdi, .sel_n);
    pbwc_top #(.DB160_CYC(20), .DB40_CYC(10), .DB10_CYC(5), .TICK_CYC(TICK)) dut_u (
        .clk, .rst, .sck, .sdi, .sel_n, .key_n, .osc_stable, .pll_locked, .supply_mv,
        .key_pullup_on, .key_run, .combo_run, .rf, .battery_low_flag, .wake_event,
        .asleep);
    always #25 clk = ~clk;
    // ****
    // Helpers
    // ****
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [15:0] w);
        host_u.send(w, 16);
        repeat (8) @(negedge clk);
    endtask : wr
    function automatic int wake_cyc(input int mul, input int e);
        return ((mul << e) == 0 ? 1 : (mul << e)) * TICK;
    endfunction : wake_cyc
    task automatic press(input logic [3:0] mask, input int k, input int hold,
                         output int first, output int cnt);
        first = -1;
        cnt = 0;
        key_n = ~mask;
        for (int i = 0; i < hold; i++) begin
            @(negedge clk);
            if ((k < 4 ? key_run[k[1:0]] : combo_run) === 1'b1) begin
                cnt++;
                first = (first < 0) ? i : first;
            end
        end
        key_n = 4'hf;
        repeat (40) @(negedge clk);
    endtask : press
    task automatic wake_gap(output int g);
        int i;
        g = -1;
        for (i = 0; i < 3000 && wake_event !== 1'b1; i++)
            @(negedge clk);
        for (i = 1; i < 3000 && g < 0; i++) begin
            @(negedge clk);
            g = (wake_event === 1'b1) ? i : g;
        end
    endtask : wake_gap
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            final_report();
        end
    end
    // ****
    // Tests
    // ****
    initial begin
        int k, m, first, cnt, g, i, thr;
        logic [7:0] r;
        key_n = 4'hf;
        osc_stable = 1'b0;
        pll_locked = 1'b0;
        supply_mv = 13'd5000;
        void'($urandom(30676));
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk("pullup_rst", 16'h000f, {12'h0, key_pullup_on});
        chk("rf_rst", 16'h0011, {11'h0, rf});
        wr(16'hca01);
        chk("pullup_off", 16'h0000, {12'h0, key_pullup_on});
        wr(16'hcb00);
        host_u.send(16'hca00, 8);
        repeat (8) @(negedge clk);
        chk("pullup_kept", 16'h0000, {12'h0, key_pullup_on});
        wr(16'hca00);
        chk("pullup_on", 16'h000f, {12'h0, key_pullup_on});
        $display("test button word done");
        for (k = 0; k < 4; k++) begin
            m = $urandom_range(3, 0);
            g = (k == 0) ? 20 : (k == 1) ? 10 : (k == 2) ? 5 : 0;
            wr(16'hca00 | 16'(k << 5));
            press(4'(1 << m), m, 40, first, cnt);
            chk("db_first", 16'h1, 16'(first >= g + 1 && first <= g + 5));
            chk("db_once", 16'h1, 16'(cnt));
        end
        wr(16'hca60 | 16'(2 << m));
        press(4'(1 << m), m, 20, first, cnt);
        chk("repeat", 16'h1, 16'(cnt > 10));
        $display("test keys done");
        wr(16'hcae0);
        press(4'h3, 4, 20, first, cnt);
        chk("combo", 16'h1, 16'(cnt));
        press(4'h8, 3, 20, first, cnt);
        chk("key_four", 16'h1, 16'(cnt));
        wr(16'hca60);
        press(4'h3, 4, 20, first, cnt);
        chk("combo_off", 16'h0, 16'(cnt));
        $display("test combo done");
        for (k = 0; k < 4; k++) begin
            r = 8'($urandom_range(7, 0));
            wr(16'hc000 | 16'(r << 3));
            chk("pwr", {13'h0, 3'h4 | r[2:0]}, {13'h0, rf.xtal_on, rf.pll_on, rf.amp_on});
        end
        wr(16'hc000);
        wr(16'hc010);
        chk("vco_cal", 16'h1, {15'h0, rf.vco_cal});
        wr(16'hc001);
        chk("all_off", 16'h0, {11'h0, rf});
        wr(16'hc021);
        chk("osc_only", 16'h2, {14'h0, rf.xtal_on, rf.clock_out_on});
        $display("test power done");
        for (k = 0; k < 3; k++) begin
            r = (k == 0) ? 8'h00 : (k == 1) ? 8'($urandom_range(40, 1)) : 8'hff;
            wr(16'hc038);
            fork
                host_u.send(16'hc400 | {8'h0, r}, 16);
                begin
                    for (i = 0; i < 3000 && rf.pll_on !== 1'b0; i++)
                        @(negedge clk);
                    for (g = 0; g < 400 && rf.clock_out_on === 1'b1; g++)
                        @(negedge clk);
                end
            join
            repeat (4) @(negedge clk);
            chk("sleep_hold", 16'h1, 16'(g + 2 >= r && g <= r + 4));
            chk("asleep", 16'h1, {15'h0, asleep});
        end
        wr(16'hc000);
        chk("awake", 16'h1, {14'h0, asleep, rf.clock_out_on});
        $display("test sleep done");
        for (k = 0; k < 3; k++) begin
            m = (k == 0) ? 0 : (k == 1) ? $urandom_range(4, 1) : 3;
            i = (k == 0) ? 16 : (k == 1) ? $urandom_range(2, 0) : 2;
            wr(16'he000 | 16'(i << 8) | 16'(m));
            wr(16'hc000);
            wr(16'hc002);
            wake_gap(g);
            chk("wake_gap", 16'(wake_cyc(m, i)), 16'(g));
        end
        wr(16'hc000);
        for (cnt = 0, i = 0; i < 200; i++) begin
            @(negedge clk);
            cnt += (wake_event === 1'b1);
        end
        chk("wake_off", 16'h0, 16'(cnt));
        $display("test wake done");
        r = 8'($urandom_range(31, 0));
        thr = 2200 + 100 * r;
        wr(16'hc200 | {11'h0, r[4:0]});
        wr(16'hc004);
        supply_mv = 13'(thr - 50);
        repeat (8) @(negedge clk);
        chk("batt_low", 16'h1, {15'h0, battery_low_flag});
        supply_mv = 13'(thr - 49);
        repeat (8) @(negedge clk);
        chk("batt_ok", 16'h0, {15'h0, battery_low_flag});
        supply_mv = 13'(thr - 60);
        wr(16'hc000);
        chk("batt_off", 16'h0, {15'h0, battery_low_flag});
        $display("test battery done");
        for (m = 1; m < 4; m++) begin
            osc_stable = 1'b0;
            pll_locked = 1'b0;
            wr(16'hc001 | 16'(m << 6) | (m == 1 ? 16'h0030 : 16'h0000));
            wr(16'hc600);
            chk("auto_wait", {14'h0, 1'b1, m == 1}, {14'h0, rf.xtal_on, rf.pll_on});
            osc_stable = 1'b1;
            repeat (6) @(negedge clk);
            chk("auto_pll", 16'h2, {14'h0, rf.pll_on, rf.amp_on});
            pll_locked = 1'b1;
            repeat (6) @(negedge clk);
            chk("auto_amp", 16'(m & 1), {15'h0, rf.amp_on});
            wr(16'hc000);
        end
        $display("test auto chain done");
        final_report();
    end
endmodule : tb_power_button_wake_control
bind pbwc_top pbwc_chk #(.TICK_CYC(TICK_CYC)) chk_u (
    .clk, .rst, .key_n, .key_pullup_on, .key_run, .combo_run, .rf, .wake_event, .asleep);
